// ### bgp_params.svh
// Constants for the button group and polarity register block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef BGP_PARAMS_SVH
`define BGP_PARAMS_SVH

// Channel count and processed data width
`define BGP_NUM_CH 4
`define BGP_DATA_W 16

// Register offsets on the serial port
`define BGP_REG_GROUP_OFS 8'h1A
`define BGP_REG_POL_OFS 8'h1C

// Reset values
`define BGP_GROUP_RST 8'h00
`define BGP_POL_RST 8'h0F
`define BGP_PIN_RST 1'b1

// Field positions inside the two registers
`define BGP_COMMON_LSB 4
`define BGP_DEFORM_LSB 0
`define BGP_PINPOL_LSB 4
`define BGP_DSIGN_LSB 0

// Serial port constants; the address is arbitrary
`define BGP_DEV_ADDR 7'h2A
`define BGP_BIT_FULL 4'h8
`define BGP_BIT_ONE 4'h1
`define BGP_BIT_ZERO 4'h0
`define BGP_UNMAPPED_RD 8'h00
`define BGP_PTR_STEP 8'h01

`endif

// ### bgp_pkg.sv
// Types shared by the register block and its per-channel output stage.
// Assumes bgp_params.svh is reachable by bare name.
`include "bgp_params.svh"

package bgp_pkg;

  typedef enum logic [3:0] {
    BGP_IDLE = 4'b0000,
    BGP_ADDR = 4'b0001,
    BGP_ADDR_ACK = 4'b0010,
    BGP_PTR = 4'b0011,
    BGP_PTR_ACK = 4'b0100,
    BGP_WDATA = 4'b0101,
    BGP_WDATA_ACK = 4'b0110,
    BGP_RDATA = 4'b0111,
    BGP_RDATA_ACK = 4'b1000
  } bgp_i2c_st_e;

  typedef struct packed {
    logic press;
    logic signed [`BGP_DATA_W-1:0] freq_delta;
  } bgp_chan_in_s;

  typedef struct packed {
    logic button_pin;
    logic signed [`BGP_DATA_W-1:0] processed_value;
  } bgp_chan_out_s;

  typedef struct packed {
    logic pin_q;
    logic signed [`BGP_DATA_W-1:0] value_q;
  } bgp_chan_state_s;

  typedef struct packed {
    bgp_i2c_st_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_oe;
    logic [7:0] group_q;
    logic [7:0] pol_q;
    logic scl_s1;
    logic scl_s2;
    logic scl_p;
    logic sda_s1;
    logic sda_s2;
    logic sda_p;
  } bgp_state_s;

endpackage : bgp_pkg

// ### bgp_chan.sv
// Per-channel output stage: pin polarity and data sign.
// Assumes press and frequency delta come from logic on clk.
`timescale 1ns/1ns
`include "bgp_params.svh"

module bgp_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire logic pin_polarity,
  input wire logic data_sign,
  // Channel data
  input bgp_pkg::bgp_chan_in_s chan_in,
  output bgp_pkg::bgp_chan_out_s chan_out
);
  import bgp_pkg::*;

  localparam bgp_chan_state_s RST = '{pin_q: `BGP_PIN_RST, value_q: '0};

  bgp_chan_state_s st_q;
  bgp_chan_state_s st_d;

  always_comb begin
    st_d = st_q;
    // Press detection stays untouched, only the pin sense flips
    if (pin_polarity) begin
      st_d.pin_q = chan_in.press;
    end else begin
      st_d.pin_q = ~chan_in.press;
    end
    // Most negative input wraps on negation; range is one short
    if (data_sign) begin
      st_d.value_q = chan_in.freq_delta;
    end else begin
      st_d.value_q = -chan_in.freq_delta;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign chan_out.button_pin = st_q.pin_q;
  assign chan_out.processed_value = st_q.value_q;

endmodule : bgp_chan

// ### bgp_regs.sv
// Button group and polarity registers behind a two-wire serial slave.
// Assumes SCL and SDA arrive asynchronous; SDA is open drain, low only.
`timescale 1ns/1ns
`include "bgp_params.svh"

module bgp_regs #(
  parameter logic [6:0] DEV_ADDR = `BGP_DEV_ADDR
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Two-wire serial port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Channel data
  input bgp_pkg::bgp_chan_in_s [`BGP_NUM_CH-1:0] chan_in,
  output bgp_pkg::bgp_chan_out_s [`BGP_NUM_CH-1:0] chan_out,
  // Group membership to the post-processing
  output logic [`BGP_NUM_CH-1:0] common_reject_member,
  output logic [`BGP_NUM_CH-1:0] deform_mitigate_member
);
  import bgp_pkg::*;

  localparam bgp_state_s RST = '{
    st: BGP_IDLE,
    bit_cnt: `BGP_BIT_ZERO,
    shreg: '0,
    ptr: '0,
    rw: 1'b0,
    mack: 1'b0,
    sda_oe: 1'b0,
    group_q: `BGP_GROUP_RST,
    pol_q: `BGP_POL_RST,
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    scl_p: 1'b1,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    sda_p: 1'b1
  };

  bgp_state_s st_q;
  bgp_state_s st_d;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rd_byte;

  // Whole-byte read of the two registers, unmapped reads as zero
  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input logic [7:0] group_v,
    input logic [7:0] pol_v
  );
    case (addr)
      `BGP_REG_GROUP_OFS: begin
        reg_read = group_v;
      end
      `BGP_REG_POL_OFS: begin
        reg_read = pol_v;
      end
      default: begin
        reg_read = `BGP_UNMAPPED_RD;
      end
    endcase
  endfunction : reg_read

  // Edges compare the second stage against the third (scl_p, sda_p)
  assign scl_rise = st_q.scl_s2 & ~st_q.scl_p;
  assign scl_fall = ~st_q.scl_s2 & st_q.scl_p;
  assign bus_start = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
  assign bus_stop = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
  assign rd_byte = reg_read(st_q.ptr, st_q.group_q, st_q.pol_q);

  always_comb begin
    st_d = st_q;
    st_d.scl_s1 = scl_in;
    st_d.scl_s2 = st_q.scl_s1;
    st_d.scl_p = st_q.scl_s2;
    st_d.sda_s1 = sda_in;
    st_d.sda_s2 = st_q.sda_s1;
    st_d.sda_p = st_q.sda_s2;

    case (st_q.st)
      BGP_IDLE: begin
        st_d.sda_oe = 1'b0;
      end

      BGP_ADDR: begin
        if (scl_rise) begin
          st_d.shreg = {st_q.shreg[6:0], st_q.sda_s2};
          st_d.bit_cnt = st_q.bit_cnt + `BGP_BIT_ONE;
        end else if (scl_fall && st_q.bit_cnt == `BGP_BIT_FULL) begin
          if (st_q.shreg[7:1] == DEV_ADDR) begin
            st_d.sda_oe = 1'b1;
            st_d.rw = st_q.shreg[0];
            st_d.st = BGP_ADDR_ACK;
          end else begin
            // Not our address: stay off the bus until the next start
            st_d.st = BGP_IDLE;
          end
        end
      end

      BGP_ADDR_ACK: begin
        if (scl_fall) begin
          st_d.bit_cnt = `BGP_BIT_ZERO;
          if (st_q.rw) begin
            st_d.sda_oe = ~rd_byte[7];
            st_d.shreg = {rd_byte[6:0], 1'b0};
            st_d.bit_cnt = `BGP_BIT_ONE;
            st_d.ptr = st_q.ptr + `BGP_PTR_STEP;
            st_d.st = BGP_RDATA;
          end else begin
            st_d.sda_oe = 1'b0;
            st_d.st = BGP_PTR;
          end
        end
      end

      BGP_PTR: begin
        if (scl_rise) begin
          st_d.shreg = {st_q.shreg[6:0], st_q.sda_s2};
          st_d.bit_cnt = st_q.bit_cnt + `BGP_BIT_ONE;
        end else if (scl_fall && st_q.bit_cnt == `BGP_BIT_FULL) begin
          st_d.ptr = st_q.shreg;
          st_d.sda_oe = 1'b1;
          st_d.st = BGP_PTR_ACK;
        end
      end

      BGP_PTR_ACK: begin
        if (scl_fall) begin
          st_d.sda_oe = 1'b0;
          st_d.bit_cnt = `BGP_BIT_ZERO;
          st_d.st = BGP_WDATA;
        end
      end

      BGP_WDATA: begin
        if (scl_rise) begin
          st_d.shreg = {st_q.shreg[6:0], st_q.sda_s2};
          st_d.bit_cnt = st_q.bit_cnt + `BGP_BIT_ONE;
        end else if (scl_fall && st_q.bit_cnt == `BGP_BIT_FULL) begin
          // Whole byte only; unmapped writes are acknowledged and dropped
          case (st_q.ptr)
            `BGP_REG_GROUP_OFS: begin
              st_d.group_q = st_q.shreg;
            end
            `BGP_REG_POL_OFS: begin
              st_d.pol_q = st_q.shreg;
            end
            default: begin
              st_d.group_q = st_q.group_q;
            end
          endcase
          st_d.ptr = st_q.ptr + `BGP_PTR_STEP;
          st_d.sda_oe = 1'b1;
          st_d.st = BGP_WDATA_ACK;
        end
      end

      BGP_WDATA_ACK: begin
        if (scl_fall) begin
          st_d.sda_oe = 1'b0;
          st_d.bit_cnt = `BGP_BIT_ZERO;
          st_d.st = BGP_WDATA;
        end
      end

      BGP_RDATA: begin
        if (scl_fall) begin
          if (st_q.bit_cnt == `BGP_BIT_FULL) begin
            // Release SDA for the master's acknowledge
            st_d.sda_oe = 1'b0;
            st_d.st = BGP_RDATA_ACK;
          end else begin
            st_d.sda_oe = ~st_q.shreg[7];
            st_d.shreg = {st_q.shreg[6:0], 1'b0};
            st_d.bit_cnt = st_q.bit_cnt + `BGP_BIT_ONE;
          end
        end
      end

      BGP_RDATA_ACK: begin
        if (scl_rise) begin
          st_d.mack = ~st_q.sda_s2;
        end else if (scl_fall) begin
          if (st_q.mack) begin
            // Reads have no side effect beyond the pointer step
            st_d.sda_oe = ~rd_byte[7];
            st_d.shreg = {rd_byte[6:0], 1'b0};
            st_d.bit_cnt = `BGP_BIT_ONE;
            st_d.ptr = st_q.ptr + `BGP_PTR_STEP;
            st_d.st = BGP_RDATA;
          end else begin
            st_d.st = BGP_IDLE;
          end
        end
      end

      default: begin
        st_d.sda_oe = 1'b0;
        st_d.st = BGP_IDLE;
      end
    endcase

    // Start and stop override any byte in flight
    if (bus_stop) begin
      st_d.sda_oe = 1'b0;
      st_d.st = BGP_IDLE;
    end else if (bus_start) begin
      st_d.sda_oe = 1'b0;
      st_d.bit_cnt = `BGP_BIT_ZERO;
      st_d.st = BGP_ADDR;
    end
  end

  // Registers come up with no group member and pins active low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = st_q.sda_oe;

  // Membership bits go straight from the flops to the group logic
  assign common_reject_member = st_q.group_q[`BGP_COMMON_LSB +: `BGP_NUM_CH];
  assign deform_mitigate_member = st_q.group_q[`BGP_DEFORM_LSB +: `BGP_NUM_CH];

  genvar ch;
  generate
    for (ch = 0; ch < `BGP_NUM_CH; ch = ch + 1) begin : g_chan
      bgp_chan u_chan (
        .clk(clk),
        .nrst(nrst),
        .pin_polarity(st_q.pol_q[`BGP_PINPOL_LSB + ch]),
        .data_sign(st_q.pol_q[`BGP_DSIGN_LSB + ch]),
        .chan_in(chan_in[ch]),
        .chan_out(chan_out[ch])
      );
    end
  endgenerate

endmodule : bgp_regs

// ### bgp_regs_chk.sv
// Port checker for the group and polarity registers.
// Assumes a bind onto bgp_regs.
`timescale 1ns/1ns
`include "bgp_params.svh"

module bgp_regs_chk (
  // Clock
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic scl_in,
  input bgp_pkg::bgp_chan_in_s [`BGP_NUM_CH-1:0] chan_in,
  input bgp_pkg::bgp_chan_out_s [`BGP_NUM_CH-1:0] chan_out,
  input wire logic [`BGP_NUM_CH-1:0] common_reject_member,
  input wire logic [`BGP_NUM_CH-1:0] deform_mitigate_member
);
  import bgp_pkg::*;
  logic [3:0] quiet_q;
  logic quiet;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Eight clocks without SCL low: no config update in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst || !scl_in) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  assign quiet = (quiet_q >= 4'h8);
  AST_RST_GRP: assert property ($rose(nrst) |-> common_reject_member == 4'h0 && deform_mitigate_member == 4'h0)
    else $error("groups not clear");
  AST_RST_PIN: assert property ($rose(nrst) |=> chan_out[0].button_pin == ~$past(chan_in[0].press))
    else $error("pin not active low");
  AST_RST_VAL: assert property ($rose(nrst) |=> chan_out[1].processed_value == $past(chan_in[1].freq_delta))
    else $error("value sign wrong");
  AST_VAL_SIGN: assert property ($past(nrst) |-> chan_out[3].processed_value == $past(chan_in[3].freq_delta) ||
    chan_out[3].processed_value == -$past(chan_in[3].freq_delta)) else $error("value magnitude wrong");
  AST_PIN_FOLLOW: assert property (quiet && $changed(chan_in[2].press) |=> $changed(chan_out[2].button_pin))
    else $error("pin missed press");
  AST_PIN_HOLD: assert property (quiet && $stable(chan_in[1].press) |=> $stable(chan_out[1].button_pin))
    else $error("pin moved");
  AST_VAL_HOLD: assert property (quiet && $stable(chan_in[0].freq_delta) |=> $stable(chan_out[0].processed_value))
    else $error("value moved");
  AST_GRP_HOLD: assert property (quiet |-> $stable(common_reject_member) && $stable(deform_mitigate_member))
    else $error("groups moved");
endmodule : bgp_regs_chk

bind bgp_regs bgp_regs_chk i_bgp_regs_chk (.clk(clk), .nrst(nrst), .scl_in(scl_in), .chan_in(chan_in),
  .chan_out(chan_out), .common_reject_member(common_reject_member), .deform_mitigate_member(deform_mitigate_member));

// ### bgp_host.sv
// Two-wire host model, always starting at offset 1A.
// Assumes a pull-up on sda; scl stands high between frames.
`timescale 1ns/1ns
`include "bgp_params.svh"

module bgp_host #(
  parameter logic [6:0] DEV_ADDR = `BGP_DEV_ADDR
) (
  // Bus
  input wire logic clk,
  output logic scl = 1'b1,
  output logic sda_pull = 1'b0,
  input wire logic sda,
  // Read results
  output logic res_v = 1'b0,
  output logic [7:0] res_d = 8'h00
);
  // Five clocks a phase, above the four clock minimum
  task automatic put(input logic c, input logic p);
    @(posedge clk);
    scl <= c;
    sda_pull <= p;
    res_v <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : put
  // Start when a is 0, stop when a is 1
  task automatic edge2(input logic a);
    put(1'b0, sda_pull);
    put(1'b0, a);
    put(1'b1, a);
    put(1'b1, ~a);
  endtask : edge2
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r, output logic nack);
    for (int i = 8; i >= 0; i--) begin
      put(1'b0, sda_pull);
      put(1'b0, i ? ~w[i-1] : ~last);
      put(1'b1, sda_pull);
      if (i) r[i-1] = sda; else nack = sda;
    end
  endtask : xfer
  task automatic op(input logic rd, input logic [23:0] d);
    logic [7:0] r;
    logic k;
    edge2(1'b0);
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, k);
    xfer(8'h1a, 1'b1, r, k);
    if (rd) begin
      edge2(1'b0);
      xfer({DEV_ADDR, 1'b1}, 1'b1, r, k);
    end
    for (int i = 2; i >= 0; i--) begin
      xfer(rd ? 8'hff : d[8*i +: 8], rd ? i == 0 : 1'b1, r, k);
      res_d <= r;
      res_v <= rd;
    end
    edge2(1'b1);
  endtask : op
endmodule : bgp_host

// ### bgp_regs_bench.sv
// Bench for the group and polarity registers.
// Assumes bgp_host as bus partner and the bound checker.
`timescale 1ns/1ns
`include "bgp_params.svh"

module bgp_regs_bench;
  import bgp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic scl;
  logic sda_pull;
  logic sda_out;
  logic sda_oe;
  logic res_v;
  logic [7:0] res_d;
  logic ch_v = 1'b0;
  bgp_chan_in_s [3:0] chan_in = '0;
  bgp_chan_out_s [3:0] chan_out;
  logic [3:0] com_m;
  logic [3:0] def_m;
  logic [7:0] bq[$];
  logic [75:0] cq[$];
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  wire sda = ~(sda_pull | (sda_oe & ~sda_out));
  bgp_regs i_bgp_regs (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .chan_in(chan_in), .chan_out(chan_out), .common_reject_member(com_m), .deform_mitigate_member(def_m));
  bgp_host i_bgp_host (.clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda), .res_v(res_v), .res_d(res_d));
  always #25 clk = ~clk;
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic cmp_b(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: byte %h not %h", $time, g, e);
    end
  endtask : cmp_b
  task automatic cmp_c(input logic [75:0] g, input logic [75:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: outputs %h not %h", $time, g, e);
    end
  endtask : cmp_c
  function automatic logic [75:0] exp_ch(input logic [7:0] g, input logic [7:0] p);
    bgp_chan_out_s [3:0] o;
    for (int n = 0; n < 4; n++) begin
      o[n].button_pin = chan_in[n].press ~^ p[4+n];
      o[n].processed_value = p[n] ? chan_in[n].freq_delta : -chan_in[n].freq_delta;
    end
    return {g, o};
  endfunction : exp_ch
  task automatic probe(input logic [7:0] g, input logic [7:0] p);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      chan_in <= 68'({$urandom, $urandom, $urandom});
      repeat (2) @(posedge clk);
      cq.push_back(exp_ch(g, p));
      ch_v <= 1'b1;
      @(posedge clk);
      ch_v <= 1'b0;
    end
  endtask : probe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (res_v) cmp_b(res_d, bq.pop_front());
    if (ch_v) cmp_c({com_m, def_m, chan_out}, cq.pop_front());
    if (cyc == 40000) begin
      n_mismatch++;
      $display("Error %0t: timeout", $time);
      stop_test();
    end
  end
  initial begin
    logic [7:0] g;
    logic [7:0] p;
    void'($urandom(32'h5b63));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    bq = '{8'h00, 8'h00, 8'h0f};
    i_bgp_host.op(1'b1, 24'h0000_00);
    probe(8'h00, 8'h0f);
    $display("Test reset values done");
    // First pass sets every common reject member, clears every deform member and flips every polarity
    for (int t = 0; t < 6; t++) begin
      g = t ? 8'($urandom) : 8'hf0;
      p = t ? 8'($urandom) : 8'hf0;
      i_bgp_host.op(1'b0, {g, 8'($urandom), p});
      bq.push_back(g);
      bq.push_back(8'h00);
      bq.push_back(p);
      i_bgp_host.op(1'b1, 24'h0000_00);
      probe(g, p);
      $display("Test write pass %0d done", t);
    end
    stop_test();
  end
endmodule : bgp_regs_bench
